//--- shared/sent_pkg.sv
// Shared constants, register map and checksum helpers for the nibble link block
`default_nettype none
package sent_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	// Register indices
	localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STAT = 3'h1;
	localparam logic [ADDR_W-1:0] REG_TICK_SMAX = 3'h2;
	localparam logic [ADDR_W-1:0] REG_FRAME_SMIN = 3'h3;
	localparam logic [ADDR_W-1:0] REG_DATA_LO = 3'h4;
	localparam logic [ADDR_W-1:0] REG_DATA_HI = 3'h5;
	localparam logic [ADDR_W-1:0] REG_SYNC_CAPT = 3'h6;
	// Control field positions
	localparam int CTL_ENABLE = 15;
	localparam int CTL_RECEIVE = 11;
	localparam int CTL_TRIGGERED = 10;
	localparam int CTL_CHECKSUM = 8;
	localparam int CTL_PAUSE = 7;
	localparam logic [DATA_W-1:0] CTL_WMASK = 16'h8d87;
	// Status field positions
	localparam int ST_PAUSE = 7;
	localparam int ST_CRC_ERR = 3;
	localparam int ST_FRM_ERR = 2;
	localparam int ST_IDLE = 1;
	localparam int ST_SYNC_TX = 0;
	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0001;
	localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
	// Frame timing in ticks
	localparam logic [9:0] SYNC_TICKS = 10'h038;
	localparam logic [9:0] NIB_BASE = 10'h00c;
	localparam logic [9:0] NIB_TOP = 10'h01b;
	localparam logic [9:0] PAUSE_MIN = 10'h00c;
	localparam logic [9:0] PAUSE_MAX = 10'h300;
	localparam logic [9:0] LOW_TICKS = 10'h005;
	localparam logic [15:0] FRAME_CAP = 16'h07ff;
	// Nibble slot of the checksum
	localparam logic [2:0] POS_CRC = 3'h7;
	localparam logic [3:0] CRC_SEED = 4'h5;
	localparam logic [3:0] CRC_TAB [16] = '{4'h0, 4'hd, 4'h7, 4'ha, 4'he, 4'h3, 4'h9, 4'h4,
		4'h1, 4'hc, 4'h6, 4'hb, 4'hf, 4'h2, 4'h8, 4'h5};

	// Reserved count codes fall back to the nearest legal count
	function automatic logic [2:0] nib_count(input logic [2:0] code);
		return (code == 3'h0) ? 3'h1 : (code == 3'h7) ? 3'h6 : code;
	endfunction

	// Slot 0 status, slots 1..6 data, slot 7 checksum in the low nibble
	function automatic logic [3:0] nib_at(input logic [31:0] w, input logic [2:0] pos);
		return w[31-4*pos -: 4];
	endfunction

	function automatic logic [3:0] crc4(input logic [31:0] w, input logic [2:0] n);
		logic [3:0] c;
		c = CRC_SEED;
		for (int k = 1; k <= 6; k++) begin
			if (k <= int'(n)) begin
				c = w[31-4*k -: 4] ^ CRC_TAB[c];
			end
		end
		return CRC_TAB[c];
	endfunction
endpackage
`default_nettype wire

//--- logic/line_sampler.sv
// Line input synchroniser, falling edge finder and interval timer
`default_nettype none
module line_sampler #(
	parameter int UNIT_DIV = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Line
	input wire logic line_in,
	// Measurements in units of UNIT_DIV clocks
	output logic fall,
	output logic [15:0] interval,
	output logic [15:0] high_time
);
	logic s1, s2, s3, level;
	logic [15:0] div_cnt, run_cnt;
	logic unit, settled;

	assign unit = (div_cnt == 16'(UNIT_DIV - 1));
	// A change counts only once the last two stages agree
	assign settled = (s2 == s3);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= line_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b1;
			fall <= 1'b0;
		end else begin
			if (settled) begin
				level <= s3;
			end
			fall <= settled && level && !s3;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= unit ? 16'h0000 : div_cnt + 16'h0001;
		end
	end

	// Counters saturate so a dead line never wraps into a valid window
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_cnt <= 16'h0000;
			interval <= 16'h0000;
		end else if (settled && level && !s3) begin
			// The unit at the edge itself still belongs to the closing interval
			interval <= (unit && run_cnt != 16'hffff) ? run_cnt + 16'h0001 : run_cnt;
			run_cnt <= 16'h0000;
		end else if (unit && run_cnt != 16'hffff) begin
			run_cnt <= run_cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_time <= 16'h0000;
		end else if (!level) begin
			high_time <= 16'h0000;
		end else if (unit && high_time != 16'hffff) begin
			high_time <= high_time + 16'h0001;
		end
	end
endmodule // line_sampler
`default_nettype wire

//--- logic/sent_link.sv
// Single-wire nibble link: transmitter, receiver and register file
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module sent_link #(
	parameter int UNIT_DIV = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [sent_pkg::ADDR_W-1:0] addr,
	input wire logic [sent_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [sent_pkg::DATA_W-1:0] rdata,
	// Line pin
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_n,
	// Events
	output logic frame_done
);
	import sent_pkg::*;

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_SYNC = 4'b0010,
		TX_NIB = 4'b0100,
		TX_PAUSE = 4'b1000
	} tx_state_t;
	typedef enum logic [2:0] {
		RX_WAIT = 3'b001,
		RX_NIB = 3'b010,
		RX_PAUSE = 3'b100
	} rx_state_t;

	logic [15:0] link_control_one, tick_or_sync_max_reg, frame_or_sync_min_reg, captured_sync_time;
	logic [31:0] frame_data_words, tx_words, rx_shadow;
	logic module_enable, receive_select, triggered_transmit_select, hw_checksum_enable, pause_pulse_present;
	logic [2:0] nibbles;
	logic tx_run, rx_run, tx_trigger, framing_error_flag, crc_error, line_idle_flag;
	tx_state_t tx_state;
	rx_state_t rx_state;
	logic [15:0] tick_cnt;
	logic tick, seg_end, tx_done, rx_done;
	logic [9:0] seg_tick, seg_len, next_seg_len;
	logic [11:0] frame_ticks;
	logic [2:0] tx_pos, rx_pos, next_tx_pos;
	logic [3:0] tx_crc;
	logic fall, sync_ok, nib_ok;
	logic [15:0] interval, high_time;
	logic [3:0] nib_val;

	assign module_enable = link_control_one[CTL_ENABLE];
	assign receive_select = link_control_one[CTL_RECEIVE];
	assign triggered_transmit_select = link_control_one[CTL_TRIGGERED];
	assign hw_checksum_enable = link_control_one[CTL_CHECKSUM];
	assign pause_pulse_present = link_control_one[CTL_PAUSE];
	assign nibbles = nib_count(link_control_one[2:0]);
	assign tx_run = module_enable && !receive_select;
	assign rx_run = module_enable && receive_select;

	line_sampler #(.UNIT_DIV(UNIT_DIV)) sampler (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.line_in(line_in),
		.fall(fall),
		.interval(interval),
		.high_time(high_time)
	);

	// Round interval to ticks against the captured sync (56 ticks); half-tick margins
	function automatic logic [4:0] decode(input logic [15:0] iv, input logic [15:0] sync);
		logic [23:0] scaled;
		logic [23:0] s;
		logic [4:0] res;
		scaled = 24'({8'h00, iv} * 24'd112);
		s = {8'h00, sync};
		res = 5'h00;
		for (int n = 0; n < 16; n++) begin
			if (scaled >= 24'(s * 24'(2 * n + 23)) && scaled < 24'(s * 24'(2 * n + 25))) begin
				res = {1'b1, 4'(n)};
			end
		end
		return res;
	endfunction

	assign {nib_ok, nib_val} = decode(interval, captured_sync_time);
	assign sync_ok = interval >= frame_or_sync_min_reg && interval <= tick_or_sync_max_reg;

	// Tick generator
	assign tick = (tx_state != TX_IDLE) && (tick_cnt == tick_or_sync_max_reg);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= 16'h0000;
		end else if (tx_state == TX_IDLE || tick) begin
			tick_cnt <= 16'h0000;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end

	assign seg_end = tick && (seg_tick == seg_len - 10'h001);
	assign tx_crc = hw_checksum_enable ? crc4(tx_words, nibbles) : tx_words[3:0];
	assign tx_done = seg_end && tx_state == TX_NIB && tx_pos == POS_CRC;

	// Pause length: fill to the frame length in continuous mode with the frame up to FRAME_CAP, else PAUSE_MIN; bounded both ways
	function automatic logic [9:0] pause_len(input logic [15:0] fl, input logic [11:0] used, input logic async);
		logic [15:0] want;
		want = (fl > {4'h0, used}) ? fl - {4'h0, used} : 16'h0000;
		if (!async || fl > FRAME_CAP || want < {6'h00, PAUSE_MIN}) begin
			return PAUSE_MIN;
		end
		return (want > {6'h00, PAUSE_MAX}) ? PAUSE_MAX : want[9:0];
	endfunction

	always_comb begin
		next_tx_pos = tx_pos;
		next_seg_len = seg_len;
		if (tx_state == TX_SYNC) begin
			next_tx_pos = 3'h0;
		end else if (tx_pos == nibbles) begin
			next_tx_pos = POS_CRC;
		end else begin
			next_tx_pos = tx_pos + 3'h1;
		end
		if (next_tx_pos == POS_CRC) begin
			next_seg_len = NIB_BASE + {6'h00, tx_crc};
		end else begin
			next_seg_len = NIB_BASE + {6'h00, nib_at(tx_words, next_tx_pos)};
		end
	end

	// Transmit sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= TX_IDLE;
			seg_tick <= 10'h000;
			seg_len <= SYNC_TICKS;
			tx_pos <= 3'h0;
			frame_ticks <= 12'h000;
			tx_words <= 32'h00000000;
		end else if (!tx_run) begin
			tx_state <= TX_IDLE;
			tx_pos <= 3'h0;
		end else begin
			if (tick) begin
				seg_tick <= seg_end ? 10'h000 : seg_tick + 10'h001;
				frame_ticks <= frame_ticks + 12'h001;
			end
			unique case (tx_state)
				TX_IDLE: begin
					if (!triggered_transmit_select || tx_trigger) begin
						tx_state <= TX_SYNC;
						seg_len <= SYNC_TICKS;
						seg_tick <= 10'h000;
						frame_ticks <= 12'h000;
						tx_words <= frame_data_words;
					end
				end
				TX_SYNC: begin
					if (seg_end) begin
						tx_state <= TX_NIB;
						tx_pos <= next_tx_pos;
						seg_len <= next_seg_len;
					end
				end
				TX_NIB: begin
					if (seg_end && tx_pos != POS_CRC) begin
						tx_pos <= next_tx_pos;
						seg_len <= next_seg_len;
					end else if (seg_end && pause_pulse_present) begin
						tx_state <= TX_PAUSE;
						seg_len <= pause_len(frame_or_sync_min_reg, frame_ticks + 12'h001,
							!triggered_transmit_select);
					end else if (seg_end) begin
						tx_state <= triggered_transmit_select ? TX_IDLE : TX_SYNC;
						seg_len <= SYNC_TICKS;
						frame_ticks <= 12'h000;
						tx_words <= frame_data_words;
					end
				end
				TX_PAUSE: begin
					if (seg_end) begin
						tx_state <= triggered_transmit_select ? TX_IDLE : TX_SYNC;
						seg_len <= SYNC_TICKS;
						frame_ticks <= 12'h000;
						tx_words <= frame_data_words;
					end
				end
			endcase
		end
	end

	// Each segment opens with a low pulse: one falling edge per interval
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_out <= 1'b1;
			line_oe_n <= 1'b1;
		end else begin
			line_out <= (tx_state == TX_IDLE) || (seg_tick >= LOW_TICKS);
			line_oe_n <= !tx_run;
		end
	end

	// Receive sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= RX_WAIT;
			rx_pos <= 3'h0;
			rx_shadow <= 32'h00000000;
			captured_sync_time <= WORD_RESET;
		end else if (!rx_run) begin
			rx_state <= RX_WAIT;
			rx_pos <= 3'h0;
		end else if (fall) begin
			unique case (rx_state)
				RX_WAIT: begin
					if (sync_ok) begin
						rx_state <= RX_NIB;
						rx_pos <= 3'h0;
						captured_sync_time <= interval;
					end
				end
				RX_NIB: begin
					if (!nib_ok) begin
						rx_state <= RX_WAIT;
					end else begin
						rx_shadow[31-4*rx_pos -: 4] <= nib_val;
						if (rx_pos == POS_CRC) begin
							rx_state <= pause_pulse_present ? RX_PAUSE : RX_WAIT;
						end
						rx_pos <= (rx_pos == POS_CRC) ? 3'h0 : (rx_pos == nibbles) ? POS_CRC : rx_pos + 3'h1;
					end
				end
				RX_PAUSE: begin
					rx_state <= RX_WAIT;
				end
			endcase
		end
	end

	assign rx_done = rx_run && fall && rx_state == RX_NIB && nib_ok && rx_pos == POS_CRC;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_done <= 1'b0;
		end else begin
			frame_done <= tx_done || rx_done;
		end
	end

	// Status flags; a hardware set wins over a software clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			framing_error_flag <= 1'b0;
			crc_error <= 1'b0;
			tx_trigger <= 1'b0;
			line_idle_flag <= 1'b0;
		end else begin
			if (rx_run && fall && rx_state == RX_NIB && !nib_ok) begin
				framing_error_flag <= 1'b1;
			end else if (wr && addr == REG_STAT && !wdata[ST_FRM_ERR]) begin
				framing_error_flag <= 1'b0;
			end
			if (rx_done) begin
				crc_error <= hw_checksum_enable && crc4({rx_shadow[31:4], nib_val}, nibbles) != nib_val;
			end
			if (wr && addr == REG_STAT && wdata[ST_SYNC_TX] && tx_run && triggered_transmit_select) begin
				tx_trigger <= 1'b1;
			end else if (tx_state == TX_IDLE && tx_trigger) begin
				tx_trigger <= 1'b0;
			end
			line_idle_flag <= rx_run && high_time >= tick_or_sync_max_reg;
		end
	end

	// Register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_control_one <= CTRL_RESET;
			tick_or_sync_max_reg <= WORD_RESET;
			frame_or_sync_min_reg <= WORD_RESET;
			frame_data_words <= 32'h00000000;
		end else begin
			if (wr && addr == REG_CTRL) begin
				link_control_one <= wdata & CTL_WMASK;
			end
			if (wr && addr == REG_TICK_SMAX) begin
				tick_or_sync_max_reg <= wdata;
			end
			if (wr && addr == REG_FRAME_SMIN) begin
				frame_or_sync_min_reg <= wdata;
			end
			if (rx_done) begin
				frame_data_words <= {rx_shadow[31:4], nib_val};
			end else if (wr && !receive_select && addr == REG_DATA_LO) begin
				frame_data_words[15:0] <= wdata;
			end else if (wr && !receive_select && addr == REG_DATA_HI) begin
				frame_data_words[31:16] <= wdata;
			end
		end
	end

	// Register reads, data in the following cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= WORD_RESET;
		end else if (rd) begin
			unique case (addr)
				REG_CTRL: rdata <= link_control_one;
				REG_STAT: rdata <= {8'h00, tx_state == TX_PAUSE || rx_state == RX_PAUSE,
					receive_select ? (rx_state == RX_NIB ? rx_pos : 3'h0) : (tx_state == TX_NIB ? tx_pos : 3'h0),
					crc_error, framing_error_flag, line_idle_flag,
					receive_select ? rx_state == RX_NIB :
					(triggered_transmit_select ? tx_trigger || tx_state != TX_IDLE : tx_run)};
				REG_TICK_SMAX: rdata <= tick_or_sync_max_reg;
				REG_FRAME_SMIN: rdata <= frame_or_sync_min_reg;
				REG_DATA_LO: rdata <= frame_data_words[15:0];
				REG_DATA_HI: rdata <= frame_data_words[31:16];
				REG_SYNC_CAPT: rdata <= captured_sync_time;
				default: rdata <= WORD_RESET;
			endcase
		end
	end

	// Checking helpers: ticks since the last driven falling edge
	logic [9:0] chk_ticks;
	tx_state_t chk_prev;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_ticks <= 10'h000;
			chk_prev <= TX_IDLE;
		end else if (seg_end) begin
			chk_ticks <= 10'h000;
			chk_prev <= tx_state;
		end else if (tick || tx_state == TX_IDLE) begin
			// A frame cut short by disable must not leave a stale count behind
			chk_ticks <= (tx_state == TX_IDLE) ? 10'h000 : chk_ticks + 10'h001;
		end
	end

	sequence seq_sync_fall;
		rx_run && fall && rx_state == RX_WAIT && sync_ok;
	endsequence
	sequence seq_in_frame;
		rx_state == RX_NIB && rx_pos == 3'h0;
	endsequence

	chk_sync_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seg_end && tx_state == TX_SYNC |-> chk_ticks == SYNC_TICKS - 10'h001) else $error("sync not 56 ticks");
	chk_nib_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seg_end && tx_state == TX_NIB |-> chk_ticks >= NIB_BASE - 10'h001 && chk_ticks <= NIB_TOP - 10'h001)
		else $error("nibble outside 12-27 ticks");
	chk_pause_bounds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seg_end && tx_state == TX_PAUSE |-> chk_prev == TX_NIB && chk_ticks >= PAUSE_MIN - 10'h001
		&& chk_ticks <= PAUSE_MAX - 10'h001) else $error("pause outside 12-768 ticks");
	chk_sync_accept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seq_sync_fall |=> seq_in_frame) else $error("valid sync not accepted");
	chk_sync_reject: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rx_run && fall && rx_state == RX_WAIT && !sync_ok |=> rx_state == RX_WAIT) else $error("bad sync accepted");
	chk_sync_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seq_sync_fall |=> captured_sync_time == $past(interval)) else $error("sync time not captured");
	chk_framing_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rx_run && fall && rx_state == RX_NIB && !nib_ok |=> framing_error_flag ##1 rx_state == RX_WAIT)
		else $error("framing error missed");
	chk_done_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rx_done |=> frame_done && frame_data_words[3:0] == $past(nib_val)) else $error("completion lost");
	chk_trigger_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seg_end && triggered_transmit_select && (tx_state == TX_PAUSE || tx_done && !pause_pulse_present)
		|=> tx_state == TX_IDLE ##1 !tx_trigger)
		else $error("triggered frame repeated");
	chk_tx_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!receive_select && module_enable |-> !line_oe_n || $past(!tx_run)) else $error("pin not driven");
endmodule // sent_link
`default_nettype wire

//--- test/sent_sensor_model.sv
// Behavioural far-end sensor that sends nibble frames onto the shared wire
`default_nettype none
module sent_sensor_model (
	// Clock
	input wire logic sys_clk,
	// Frame request
	input wire logic start,
	input wire logic [15:0] tick_clks,
	input wire logic [31:0] word,
	input wire logic [7:0] status_ticks,
	// Wire side
	output logic busy,
	output logic drv_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released wire floats back to the pull-up, never holds a driven level
	task automatic seg(input int ticks);
		drv_low <= 1'b1;
		repeat (5 * tick_clks) @(posedge sys_clk);
		drv_low <= 1'b0;
		repeat ((ticks - 5) * tick_clks) @(posedge sys_clk);
	endtask
	initial begin
		busy = 1'b0;
		drv_low = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (start) begin
				busy <= 1'b1;
				seg(56);
				seg((status_ticks != 8'h00) ? int'(status_ticks) : 12 + int'(word[31:28]));
				for (int k = 1; k < 8; k++) begin
					seg(12 + int'(word[31-4*k -: 4]));
				end
				// Closing fall ends the checksum nibble
				seg(12);
				busy <= 1'b0;
			end
		end
	end
endmodule // sent_sensor_model
`default_nettype wire

//--- test/sent_link_tb.sv
// Self-checking bench for the nibble link block
`default_nettype none
module sent_link_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sent_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic start = 1'b0;
	logic [15:0] tick_clks = 16'h0008;
	logic [31:0] word = '0;
	logic [7:0] status_ticks = 8'h00;
	logic [DATA_W-1:0] rdata;
	logic line_out, line_oe_n, frame_done, busy, drv_low;
	// Pull-up wire shared by both ends
	wire logic line = (line_oe_n ? 1'b1 : line_out) & ~drv_low;
	int miscompares = 0;
	int tests_run = 0;
	int done_cnt = 0;
	int cycles = 0;

	sent_link #(.UNIT_DIV(1)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .line_in(line), .line_out(line_out), .line_oe_n(line_oe_n), .frame_done(frame_done));
	sent_sensor_model u_sensor (.sys_clk(sys_clk), .start(start), .tick_clks(tick_clks), .word(word),
		.status_ticks(status_ticks), .busy(busy), .drv_low(drv_low));

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (frame_done === 1'b1) begin
			done_cnt <= done_cnt + 1;
		end
		if (cycles == 60000) begin
			miscompares = miscompares + 1;
			test_done();
		end
	end

	task automatic test_done();
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected word at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_count(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			miscompares++;
			$display("unexpected count at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		cmp_word(rdata & m, exp);
	endtask
	// Cycles up to the next falling edge; 3000 means none came
	task automatic next_fall(output int n);
		logic last;
		n = 0;
		do begin
			last = line;
			@(negedge sys_clk);
			n++;
		end while (!(last && !line) && n < 3000);
	endtask
	task automatic tx_check(input int nib, input int tc, input logic [31:0] w, input int pause, input bit cont);
		int n;
		next_fall(n);
		next_fall(n);
		cmp_count(n, 56 * tc);
		for (int i = 0; i <= nib; i++) begin
			next_fall(n);
			cmp_count(n, (12 + int'(w[31-4*i -: 4])) * tc);
		end
		next_fall(n);
		cmp_count(n, (12 + int'(w[3:0])) * tc);
		if (pause > 0) begin
			next_fall(n);
			cmp_count(n, pause * tc);
		end
		next_fall(n);
		cmp_count(n, cont ? 56 * tc : 3000);
	endtask
	task automatic send(input logic [15:0] tc, input logic [31:0] w, input logic [7:0] st, input int exp);
		int n;
		int d;
		n = 0;
		@(posedge sys_clk);
		tick_clks <= tc;
		word <= w;
		status_ticks <= st;
		start <= 1'b1;
		d = done_cnt;
		@(posedge sys_clk);
		start <= 1'b0;
		repeat (2) @(posedge sys_clk);
		while (busy === 1'b1 && n < 6000) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (20) @(posedge sys_clk);
		cmp_count(done_cnt - d, exp);
	endtask

	task automatic t_reset();
		rd_chk(REG_CTRL, 16'hffff, CTRL_RESET);
		cmp_word({14'h0000, line_oe_n, line_out}, 16'h0003);
		wr_reg(3'h7, 16'hffff);
		rd_chk(3'h7, 16'hffff, 16'h0000);
	endtask
	task automatic t_tx_cont();
		int d;
		wr_reg(REG_TICK_SMAX, 16'h0001);
		wr_reg(REG_DATA_HI, 16'h5a3c);
		wr_reg(REG_DATA_LO, 16'h0007);
		d = done_cnt;
		wr_reg(REG_CTRL, 16'h8003);
		tx_check(3, 2, 32'h5a3c0007, 0, 1'b1);
		cmp_count(done_cnt - d, 1);
		cmp_word({15'h0000, line_oe_n}, 16'h0000);
		wr_reg(REG_CTRL, 16'h0000);
	endtask
	task automatic t_tx_pause();
		wr_reg(REG_TICK_SMAX, 16'h0000);
		wr_reg(REG_FRAME_SMIN, 16'h0fff);
		wr_reg(REG_DATA_HI, 16'h1234);
		wr_reg(REG_DATA_LO, 16'h5678);
		wr_reg(REG_CTRL, 16'h8087);
		tx_check(6, 1, 32'h12345678, 12, 1'b1);
		// Frame of 920 ticks: 188 used, pause fills the rest
		wr_reg(REG_CTRL, 16'h0000);
		wr_reg(REG_FRAME_SMIN, 16'h0398);
		wr_reg(REG_CTRL, 16'h8087);
		tx_check(6, 1, 32'h12345678, 732, 1'b1);
		wr_reg(REG_CTRL, 16'h0000);
	endtask
	task automatic t_tx_trig();
		wr_reg(REG_TICK_SMAX, 16'h0001);
		wr_reg(REG_DATA_HI, 16'h9f00);
		wr_reg(REG_DATA_LO, 16'h000e);
		wr_reg(REG_CTRL, 16'h8580);
		wr_reg(REG_STAT, 16'h0001);
		// Hardware checksum of the single data nibble replaces the stored low nibble
		tx_check(1, 2, 32'h9f00000f, 0, 1'b0);
		wr_reg(REG_CTRL, 16'h0000);
	endtask
	task automatic t_rx();
		wr_reg(REG_TICK_SMAX, 16'h0219);
		wr_reg(REG_FRAME_SMIN, 16'h0167);
		wr_reg(REG_CTRL, 16'h8806);
		cmp_word({15'h0000, line_oe_n}, 16'h0001);
		send(16'h0008, 32'h3a5c1e97, 8'h00, 1);
		rd_chk(REG_DATA_HI, 16'hffff, 16'h3a5c);
		rd_chk(REG_DATA_LO, 16'hffff, 16'h1e97);
		rd_chk(REG_SYNC_CAPT, 16'hffff, 16'h01c0);
		send(16'h0009, 32'hc0ffee42, 8'h00, 1);
		rd_chk(REG_DATA_HI, 16'hffff, 16'hc0ff);
		rd_chk(REG_DATA_LO, 16'hffff, 16'hee42);
		rd_chk(REG_SYNC_CAPT, 16'hffff, 16'h01f8);
		send(16'h000a, 32'h11111111, 8'h00, 0);
		send(16'h0008, 32'h22222222, 8'h1e, 0);
		rd_chk(REG_STAT, 16'h0004, 16'h0004);
		wr_reg(REG_STAT, 16'h0000);
		rd_chk(REG_STAT, 16'h0004, 16'h0000);
		repeat (600) @(posedge sys_clk);
		rd_chk(REG_STAT, 16'h0002, 16'h0002);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_tx_cont();
		t_tx_pause();
		t_tx_trig();
		t_rx();
		test_done();
	end
endmodule // sent_link_tb
`default_nettype wire
